// [testbench/mcs_ctrl_chk.sv]
// assertion checker for the mixer channel setup control
`timescale 1ns/1ps
`include "mcs_map.vh"
module mcs_ctrl_chk (
   input wire logic                 CLK_SYS,
   input wire logic                 RST_N,
   input wire logic [`MCS_NV_W-1:0] NV_LOAD_DATA,
   input wire logic                 NV_STORE,
   input wire logic [`MCS_NV_W-1:0] NV_STORE_DATA,
   input wire logic                 SETUP_ACTIVE,
   input wire logic                 PROGRAM_BUS_SEL,
   input wire logic                 AUDITION_BUS_SEL,
   input wire logic                 INPUT_ONE_SELECT,
   input wire logic                 INPUT_TWO_SELECT,
   input wire logic                 CHANNEL_ON,
   input wire logic                 CHANNEL_LIVE,
   input wire logic [1:0]           GPIO_OE,
   input wire logic [1:0]           GPIO_OUT
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   logic [`MCS_NV_W-1:0] cfg_q;
   logic                 ld_q;
   logic [2:0]           run_q;
   wire                  run = (run_q == 3'h7);
   wire [1:0]            pm  = cfg_q[`MCS_NV_PGM +: 2];
   wire [1:0]            am  = cfg_q[`MCS_NV_AUD +: 2];
   wire [1:0]            im  = cfg_q[`MCS_NV_INP +: 2];
   // shadow of the retained word; run counts settled cycles outside setup
   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         ld_q  <= 1'b0;
         run_q <= 3'h0;
      end else begin
         ld_q <= 1'b1;
         if (!ld_q) cfg_q <= NV_LOAD_DATA;
         else if (NV_STORE) cfg_q <= NV_STORE_DATA;
         run_q <= SETUP_ACTIVE ? 3'h0 : run_q + {2'h0, run_q != 3'h7};
      end
   end
   property p_store_pulse; NV_STORE |=> !NV_STORE; endproperty
   a_store_pulse: assert property (p_store_pulse) else $error("store pulse too long");
   property p_pgm_on; run && pm == 2'h2 |-> PROGRAM_BUS_SEL; endproperty
   a_pgm_on: assert property (p_pgm_on) else $error("program bus not forced on");
   property p_pgm_off; run && pm == 2'h3 |-> !PROGRAM_BUS_SEL; endproperty
   a_pgm_off: assert property (p_pgm_off) else $error("program bus not forced off");
   property p_aud; run && am != 2'h1 |-> AUDITION_BUS_SEL == (am == 2'h2); endproperty
   a_aud: assert property (p_aud) else $error("audition bus mode ignored");
   property p_inp;
      run && im != 2'h1 |-> INPUT_TWO_SELECT == (im == 2'h2) && INPUT_ONE_SELECT == (im == 2'h3);
   endproperty
   a_inp: assert property (p_inp) else $error("input selector mode ignored");
   property p_live; CHANNEL_LIVE |-> CHANNEL_ON; endproperty
   a_live: assert property (p_live) else $error("live without channel on");
   property p_oe;
      run |-> GPIO_OE == {cfg_q[`MCS_NV_FUNC1 + 2], cfg_q[`MCS_NV_FUNC0 + 2]};
   endproperty
   a_oe: assert property (p_oe) else $error("pin direction wrong");
   property p_out;
      run && GPIO_OE[0] && cfg_q[`MCS_NV_ACT0 +: 3] == `MCS_ACT_CHAN && !cfg_q[`MCS_NV_FUNC0]
         && $past(CHANNEL_LIVE) == CHANNEL_LIVE && $past(CHANNEL_LIVE, 2) == CHANNEL_LIVE
         |-> GPIO_OUT[0] == (CHANNEL_LIVE ~^ cfg_q[`MCS_NV_FUNC0 + 1]);
   endproperty
   a_out: assert property (p_out) else $error("output pin not following live");
   c_store: cover property (NV_STORE);
   c_setup: cover property ($rose(SETUP_ACTIVE));
   c_live: cover property (CHANNEL_LIVE && GPIO_OUT[0]);
endmodule
bind mcs_ctrl mcs_ctrl_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .NV_LOAD_DATA(NV_LOAD_DATA),
   .NV_STORE(NV_STORE), .NV_STORE_DATA(NV_STORE_DATA), .SETUP_ACTIVE(SETUP_ACTIVE),
   .PROGRAM_BUS_SEL(PROGRAM_BUS_SEL), .AUDITION_BUS_SEL(AUDITION_BUS_SEL),
   .INPUT_ONE_SELECT(INPUT_ONE_SELECT), .INPUT_TWO_SELECT(INPUT_TWO_SELECT),
   .CHANNEL_ON(CHANNEL_ON), .CHANNEL_LIVE(CHANNEL_LIVE), .GPIO_OE(GPIO_OE), .GPIO_OUT(GPIO_OUT));

// [testbench/mcs_panel.sv]
// operator panel and remote connector model
`timescale 1ns/1ps
module mcs_panel (
   input  wire logic       clk,
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   output logic      [4:0] btn,
   output logic            fader,
   output wire logic [1:0] pin_in
);
   logic [1:0] ext;
   // a pin the device drives reads back its own level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
   initial begin
      btn   = 5'h00;
      fader = 1'b0;
      ext   = 2'h0;
   end
   // buttons held as a chord for a number of cycles
   task automatic hold(input logic [4:0] b, input int cyc);
      @(posedge clk);
      btn <= b;
      repeat (cyc) @(posedge clk);
   endtask
   task automatic set_fx(input logic f, input logic [1:0] e);
      @(posedge clk);
      fader <= f;
      ext   <= e;
   endtask
endmodule

// [testbench/tb_mixer_channel_setup_control.sv]
// self-checking testbench for the mixer channel setup control
`timescale 1ns/1ps
`include "mcs_map.vh"
module tb_mixer_channel_setup_control;
   logic                 clk_sys = 1'b0;
   logic                 rst_n   = 1'b0;
   wire  [4:0]           btn;
   wire                  fader, on_r, on_g, pfl_led, aud_led, aud_sel, input_two_select, chan_on, live;
   wire                  forced, setup, nv_store, pgm_sel, input_one_select, input_two_select_led;
   wire  [1:0]           pin_in, gpio_out, gpio_oe;
   wire  [`MCS_NV_W-1:0] nv_data;
   int n_errors = 0, comparisons = 0, n_stores = 0, cyc = 0, chan = 0, m_inp = 2, m_aud = 3, n;
   // inp 2, aud 3, pgm 2, pin2 latching high-true input fader, pin1 latching high-true output
   localparam logic [`MCS_NV_W-1:0] NV_INIT = {2'h2, 2'h3, 2'h2, 3'h4, 3'h2, 3'h1, 3'h6};
   mcs_ctrl #(.ENTER_CYC(2000), .EXIT_CYC(1500), .CONF_CYC(60), .SHOW_CYC(20), .FLASH_CYC(8),
      .MOM_CYC(10)) u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PROGRAM_BUS_BUTTON(btn[0]),
      .AUDITION_BUS_BUTTON(btn[1]), .PREFADE_LISTEN_BUTTON(btn[2]), .ON_BUTTON(btn[3]),
      .INPUT_SELECT_BUTTON(btn[4]), .FADER_UP(fader), .GPIO_IN(pin_in), .ON_MODE(4'h1),
      .NV_LOAD_DATA(NV_INIT), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .PROGRAM_BUS_LED(),
      .AUDITION_BUS_LED(aud_led), .PREFADE_LISTEN_LED(pfl_led), .ON_RED_LED(on_r),
      .ON_GREEN_LED(on_g), .INPUT_TWO_LED(input_two_select_led), .PROGRAM_BUS_SEL(pgm_sel),
      .AUDITION_BUS_SEL(aud_sel), .INPUT_ONE_SELECT(input_one_select), .INPUT_TWO_SELECT(input_two_select),
      .PREFADE_LISTEN_ON(), .CHANNEL_ON(chan_on),
      .CHANNEL_LIVE(live), .FADER_FORCED(forced), .SETUP_ACTIVE(setup), .NV_STORE(nv_store),
      .NV_STORE_DATA(nv_data));
   mcs_panel u_pan (.clk(clk_sys), .pin_out(gpio_out), .pin_oe(gpio_oe), .btn(btn),
      .fader(fader), .pin_in(pin_in));
   initial forever #10 clk_sys = ~clk_sys;
   task automatic final_report;
      if (n_errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic press(input logic [4:0] b);
      u_pan.hold(b, 540);
      u_pan.hold(5'h00, 540);
   endtask
   // compare ON, prefade-listen and audition LEDs as one code
   task automatic leds(input logic [2:0] exp);
      chk({on_r | on_g, pfl_led, aud_led}, exp);
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (nv_store === 1'b1) n_stores <= n_stores + 1;
      if (cyc == 60000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      void'($urandom(9736));
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      u_pan.set_fx(1'b1, 2'h0);
      repeat (600) @(posedge clk_sys);
      chk(aud_sel, 0);
      chk({input_two_select, input_one_select}, 2'h2);
      n = 1 + $urandom % 3;
      repeat (n) begin
         press(5'h08);
         chan = 1 - chan;
      end
      chk(chan_on, chan);
      chk({live, gpio_out[0]}, {chan[0], chan[0]});
      u_pan.set_fx(1'b1, 2'h2);
      repeat (600) @(posedge clk_sys);
      chk(forced, 1);
      u_pan.set_fx(1'b1, 2'h0);
      repeat (600) @(posedge clk_sys);
      chk(forced, 0);
      u_pan.hold(5'h01, 540);
      repeat (5) begin
         u_pan.hold(5'h03, 540);
         u_pan.hold(5'h01, 540);
      end
      u_pan.hold(5'h00, 600);
      chk(setup, 1);
      leds(3'b011);
      press(5'h01);
      leds(3'b111);
      press(5'h08);
      chk(n_stores, 1);
      leds(3'b100);
      press(5'h08);
      leds(3'b010);
      press(5'h08);
      leds(3'b001);
      press(5'h08);
      chk(n_stores, 4);
      press(5'h08);
      chk(setup, 0);
      u_pan.hold(5'h03, 2600);
      chk(setup, 1);
      u_pan.hold(5'h00, 600);
      n = 0;
      repeat (128) begin
         @(posedge clk_sys);
         n += input_two_select_led;
      end
      chk(n, m_inp * 8);
      repeat (2) begin
         press(5'h10);
         m_inp = m_inp % 3 + 1;
      end
      press(5'h02);
      m_aud = m_aud % 3 + 1;
      press(5'h01);
      u_pan.hold(5'h03, 1800);
      u_pan.hold(5'h00, 600);
      chk(setup, 0);
      chk(n_stores, 5);
      chk(nv_data[17:12], {m_inp[1:0], m_aud[1:0], 2'h3});
      chk(pgm_sel, 0);
      final_report();
   end
endmodule

// [verilog/mcs_ctrl.v]
// mixer channel setup control: remote pin setup, button mode setup and run logic
//
// Operation
// - pin function shown on ON, PFL, AUDITION_BUS_BUTTON LEDs
// - program cycles, ON commits, program flashes, advance
// - action list follows pin direction
// - input actions shown as LED codes
// - momentary channel-on input acts as ON press, latching one sets channel on to its level
// - red indicator input drives ON red LED
// - green indicator input drives ON green LED
// - fader-open input forces fader fully open
// - latching output channel-on drives pin while live, momentary one pulses it when going live
// - second pin configured same way after first
// - ON after second action stores, a further ON leaves setup
// - program plus audition 5 s enters mode setup
// - each button flashes its mode number
// - press increments mode, wraps to one
// - program plus audition 2 s exits setup
// - program button modes normal, on, off
// - audition button modes normal, on, off
// - input selector modes normal, two, one
// - button modes retained across power cycles
// - program held, audition five times, enters
// - remote pin settings kept non-volatile
// - program flashes fast one second on commit
`timescale 1ns/1ps
`include "mcs_map.vh"

module mcs_ctrl #(
   parameter [31:0] ENTER_CYC = `MCS_ENTER_CYC,
   parameter [31:0] EXIT_CYC  = `MCS_EXIT_CYC,
   parameter [31:0] CONF_CYC  = `MCS_CONFIRM_CYC,
   parameter [31:0] SHOW_CYC  = `MCS_SHOW_CYC,
   parameter [31:0] FLASH_CYC = `MCS_FLASH_CYC,
   parameter [31:0] MOM_CYC   = `MCS_MOM_CYC
)(
   input  wire                  CLK_SYS,
   input  wire                  RST_N,
   input  wire                  PROGRAM_BUS_BUTTON,
   input  wire                  AUDITION_BUS_BUTTON,
   input  wire                  PREFADE_LISTEN_BUTTON,
   input  wire                  ON_BUTTON,
   input  wire                  INPUT_SELECT_BUTTON,
   input  wire                  FADER_UP,
   input  wire [1:0]            GPIO_IN,
   input  wire [3:0]            ON_MODE,
   input  wire [`MCS_NV_W-1:0]  NV_LOAD_DATA,
   output reg  [1:0]            GPIO_OUT,
   output reg  [1:0]            GPIO_OE,
   output reg                   PROGRAM_BUS_LED,
   output reg                   AUDITION_BUS_LED,
   output reg                   PREFADE_LISTEN_LED,
   output reg                   ON_RED_LED,
   output reg                   ON_GREEN_LED,
   output reg                   INPUT_TWO_LED,
   output reg                   PROGRAM_BUS_SEL,
   output reg                   AUDITION_BUS_SEL,
   output reg                   INPUT_ONE_SELECT,
   output reg                   INPUT_TWO_SELECT,
   output reg                   PREFADE_LISTEN_ON,
   output reg                   CHANNEL_ON,
   output reg                   CHANNEL_LIVE,
   output reg                   FADER_FORCED,
   output reg                   SETUP_ACTIVE,
   output reg                   NV_STORE,
   output wire [`MCS_NV_W-1:0]  NV_STORE_DATA
);
   localparam [2:0] ST_RUN     = 3'h0;
   localparam [2:0] ST_RP_WAIT = 3'h1;
   localparam [2:0] ST_RP_FUNC = 3'h2;
   localparam [2:0] ST_RP_ACT  = 3'h3;
   localparam [2:0] ST_RP_DONE = 3'h4;
   localparam [2:0] ST_BM      = 3'h5;

   wire [`MCS_IN_W-1:0] db;
   reg  [`MCS_IN_W-1:0] db_q;
   wire [`MCS_IN_W-1:0] prs = db & ~db_q;
   wire [`MCS_IN_W-1:0] rel = ~db & db_q;

   reg  [2:0]  st_q;
   reg         pin_q;
   reg  [31:0] hold_q;
   reg  [31:0] tmr_q;
   reg  [31:0] conf_q;
   reg  [2:0]  aud_cnt_q;
   reg         armed_q;
   reg         combo_q;
   reg  [3:0]  slot_q;
   reg         loaded_q;
   reg  [2:0]  func_q [0:1];
   reg  [2:0]  act_q  [0:1];
   reg  [31:0] pul_q  [0:1];
   reg  [1:0]  mode_pgm_q;
   reg  [1:0]  mode_aud_q;
   reg  [1:0]  mode_inp_q;
   reg         chan_on_q;
   reg         pgm_bus_q;
   reg         aud_bus_q;
   reg         inp_two_q;
   reg         pfl_q;
   reg  [1:0]  actv_q;
   reg         live_q;

   reg  [1:0]  actv;
   reg  [1:0]  out_act;
   reg         chan_tog;
   reg         chan_set;
   reg         chan_val;
   reg         red_in;
   reg         green_in;
   reg         fader_frc;
   integer     j;
   integer     k;

   // next action in the list offered for this pin direction
   function [2:0] act_next;
      input [2:0] fn;
      input [2:0] act;
      begin
         if (fn[`MCS_FN_OUT] ? (act >= `MCS_ACT_CHAN) : (act >= `MCS_ACT_FADER))
            act_next = `MCS_ACT_NONE;
         else
            act_next = act + 3'h1;
      end
   endfunction

   // keep an action inside the list for this pin direction
   function [2:0] act_fit;
      input [2:0] fn;
      input [2:0] act;
      begin
         if (fn[`MCS_FN_OUT] ? (act > `MCS_ACT_CHAN) : (act > `MCS_ACT_FADER))
            act_fit = `MCS_ACT_NONE;
         else
            act_fit = act;
      end
   endfunction

   function [1:0] mode_inc;
      input [1:0] m;
      begin
         mode_inc = (m >= `MCS_MODE_FORCE_B) ? `MCS_MODE_NORMAL : m + 2'h1;
      end
   endfunction

   // lit during the first m odd-free slots of the sixteen-slot cycle
   function flash_lit;
      input [1:0] m;
      input [3:0] slot;
      begin
         flash_lit = ~slot[0] && (slot[3:1] < {1'b0, m});
      end
   endfunction

   mcs_debounce #(
      .W   (`MCS_IN_W),
      .CYC (`MCS_DEBOUNCE_CYC)
   ) u_debounce (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .din   ({GPIO_IN, FADER_UP, INPUT_SELECT_BUTTON, ON_BUTTON,
               PREFADE_LISTEN_BUTTON, AUDITION_BUS_BUTTON, PROGRAM_BUS_BUTTON}),
      .dout  (db)
   );

   assign NV_STORE_DATA = {mode_inp_q, mode_aud_q, mode_pgm_q,
                           act_q[1], func_q[1], act_q[0], func_q[0]};

   wire        on_gpio  = (ON_MODE == `MCS_ON_GPIO_A) || (ON_MODE == `MCS_ON_GPIO_B);
   wire        on_force = (ON_MODE >= `MCS_ON_DARK);
   wire        chan_eff = chan_on_q | on_force;
   wire        fader_ef = db[`MCS_IN_FADER] | fader_frc;
   wire        live     = chan_eff & fader_ef;
   wire [2:0]  cur_func = func_q[pin_q];
   wire [2:0]  cur_act  = act_q[pin_q];
   wire        conf_on  = (conf_q != 32'h0);
   wire        fast_lit = conf_on & conf_q[`MCS_FAST_BIT];
   wire        pgm_sel  = (mode_pgm_q == `MCS_MODE_NORMAL) ? pgm_bus_q :
                          (mode_pgm_q == `MCS_MODE_FORCE_A);
   wire        aud_sel  = (mode_aud_q == `MCS_MODE_NORMAL) ? aud_bus_q :
                          (mode_aud_q == `MCS_MODE_FORCE_A);
   wire        inp_two  = (mode_inp_q == `MCS_MODE_NORMAL) ? inp_two_q :
                          (mode_inp_q == `MCS_MODE_FORCE_A);

   // remote pin run-time decode
   always @* begin
      chan_tog  = 1'b0;
      chan_set  = 1'b0;
      chan_val  = 1'b0;
      red_in    = 1'b0;
      green_in  = 1'b0;
      fader_frc = 1'b0;
      for (j = 0; j < 2; j = j + 1) begin
         actv[j]    = db[`MCS_IN_GPIO + j] ~^ func_q[j][`MCS_FN_AH];
         out_act[j] = func_q[j][`MCS_FN_OUT] && (act_q[j] == `MCS_ACT_CHAN) &&
                      (func_q[j][`MCS_FN_MOM] ? (pul_q[j] != 32'h0) : live);
         if (!func_q[j][`MCS_FN_OUT]) begin
            if (act_q[j] == `MCS_ACT_CHAN) begin
               if (func_q[j][`MCS_FN_MOM]) begin
                  if (actv[j] && !actv_q[j])
                     chan_tog = 1'b1;
               end else if (actv[j] != actv_q[j]) begin
                  chan_set = 1'b1;
                  chan_val = actv[j];
               end
            end
            if (act_q[j] == `MCS_ACT_RED && actv[j])
               red_in = 1'b1;
            if (act_q[j] == `MCS_ACT_GREEN && actv[j])
               green_in = 1'b1;
            if (act_q[j] == `MCS_ACT_FADER && actv[j])
               fader_frc = 1'b1;
         end
      end
   end

   always @(posedge CLK_SYS) begin
      if (!RST_N) begin
         db_q       <= {`MCS_IN_W{1'b0}};
         st_q       <= ST_RUN;
         pin_q      <= 1'b0;
         hold_q     <= 32'h0;
         tmr_q      <= 32'h0;
         conf_q     <= 32'h0;
         aud_cnt_q  <= 3'h0;
         armed_q    <= 1'b0;
         combo_q    <= 1'b0;
         slot_q     <= 4'h0;
         loaded_q   <= 1'b0;
         mode_pgm_q <= `MCS_RST_MODE;
         mode_aud_q <= `MCS_RST_MODE;
         mode_inp_q <= `MCS_RST_MODE;
         chan_on_q  <= 1'b0;
         pgm_bus_q  <= 1'b0;
         aud_bus_q  <= 1'b0;
         inp_two_q  <= 1'b0;
         pfl_q      <= 1'b0;
         actv_q     <= 2'h0;
         live_q     <= 1'b0;
         NV_STORE   <= 1'b0;
         GPIO_OUT   <= 2'h0;
         GPIO_OE    <= 2'h0;
         SETUP_ACTIVE <= 1'b0;
         CHANNEL_ON <= 1'b0;
         CHANNEL_LIVE <= 1'b0;
         for (k = 0; k < 2; k = k + 1) begin
            func_q[k] <= `MCS_RST_FUNC;
            act_q[k]  <= `MCS_RST_ACT;
            pul_q[k]  <= 32'h0;
         end
      end else begin
         db_q     <= db;
         actv_q   <= actv;
         live_q   <= live;
         NV_STORE <= 1'b0;
         if (conf_on)
            conf_q <= conf_q - 32'h1;
         // long press count runs only while both buttons stay down
         if (db[`MCS_IN_PGM] && db[`MCS_IN_AUD]) begin
            if (hold_q != 32'hFFFFFFFF)
               hold_q <= hold_q + 32'h1;
         end else begin
            hold_q <= 32'h0;
         end
         for (k = 0; k < 2; k = k + 1) begin
            if (live && !live_q)
               pul_q[k] <= MOM_CYC;
            else if (pul_q[k] != 32'h0)
               pul_q[k] <= pul_q[k] - 32'h1;
         end
         if (!loaded_q) begin
            // restore retained settings once after reset
            loaded_q   <= 1'b1;
            func_q[0]  <= NV_LOAD_DATA[`MCS_NV_FUNC0 +: 3];
            act_q[0]   <= NV_LOAD_DATA[`MCS_NV_ACT0 +: 3];
            func_q[1]  <= NV_LOAD_DATA[`MCS_NV_FUNC1 +: 3];
            act_q[1]   <= NV_LOAD_DATA[`MCS_NV_ACT1 +: 3];
            mode_pgm_q <= NV_LOAD_DATA[`MCS_NV_PGM +: 2];
            mode_aud_q <= NV_LOAD_DATA[`MCS_NV_AUD +: 2];
            mode_inp_q <= NV_LOAD_DATA[`MCS_NV_INP +: 2];
         end else begin
            case (st_q)
               ST_RUN: begin
                  if (!db[`MCS_IN_PGM])
                     aud_cnt_q <= 3'h0;
                  else if (prs[`MCS_IN_AUD])
                     aud_cnt_q <= aud_cnt_q + 3'h1;
                  if (hold_q == ENTER_CYC - 32'h1) begin
                     st_q    <= ST_BM;
                     armed_q <= 1'b0;
                     combo_q <= 1'b1;
                     slot_q  <= 4'h0;
                     tmr_q   <= 32'h0;
                  end else if (db[`MCS_IN_PGM] && prs[`MCS_IN_AUD] &&
                               aud_cnt_q == 3'h4) begin
                     st_q      <= ST_RP_WAIT;
                     pin_q     <= 1'b0;
                     tmr_q     <= 32'h0;
                     aud_cnt_q <= 3'h0;
                  end else begin
                     if (prs[`MCS_IN_PGM])
                        pgm_bus_q <= ~pgm_bus_q;
                     if (prs[`MCS_IN_AUD] && !db[`MCS_IN_PGM])
                        aud_bus_q <= ~aud_bus_q;
                     if (prs[`MCS_IN_PFL])
                        pfl_q <= ~pfl_q;
                     if (prs[`MCS_IN_INP])
                        inp_two_q <= ~inp_two_q;
                     if (prs[`MCS_IN_ON] || chan_tog)
                        chan_on_q <= ~chan_on_q;
                     else if (chan_set)
                        chan_on_q <= chan_val;
                  end
               end
               ST_RP_WAIT: begin
                  if (tmr_q >= SHOW_CYC - 32'h1)
                     st_q <= ST_RP_FUNC;
                  else
                     tmr_q <= tmr_q + 32'h1;
               end
               ST_RP_FUNC: begin
                  if (!conf_on && prs[`MCS_IN_ON]) begin
                     act_q[pin_q] <= act_fit(cur_func, cur_act);
                     conf_q       <= CONF_CYC;
                     NV_STORE     <= 1'b1;
                     st_q         <= ST_RP_ACT;
                  end else if (!conf_on && prs[`MCS_IN_PGM]) begin
                     func_q[pin_q] <= cur_func + 3'h1;
                  end
               end
               ST_RP_ACT: begin
                  if (!conf_on && prs[`MCS_IN_ON]) begin
                     conf_q   <= CONF_CYC;
                     NV_STORE <= 1'b1;
                     if (!pin_q) begin
                        pin_q <= 1'b1;
                        st_q  <= ST_RP_FUNC;
                     end else begin
                        st_q <= ST_RP_DONE;
                     end
                  end else if (!conf_on && prs[`MCS_IN_PGM]) begin
                     act_q[pin_q] <= act_next(cur_func, cur_act);
                  end
               end
               ST_RP_DONE: begin
                  if (!conf_on && prs[`MCS_IN_ON])
                     st_q <= ST_RUN;
               end
               ST_BM: begin
                  if (tmr_q >= FLASH_CYC - 32'h1) begin
                     tmr_q  <= 32'h0;
                     slot_q <= slot_q + 4'h1;
                  end else begin
                     tmr_q <= tmr_q + 32'h1;
                  end
                  if (db[`MCS_IN_PGM] && db[`MCS_IN_AUD])
                     combo_q <= 1'b1;
                  else if (!db[`MCS_IN_PGM] && !db[`MCS_IN_AUD]) begin
                     combo_q <= 1'b0;
                     armed_q <= 1'b1;
                  end
                  if (armed_q && hold_q == EXIT_CYC - 32'h1) begin
                     st_q     <= ST_RUN;
                     NV_STORE <= 1'b1;
                  end else if (armed_q) begin
                     if (rel[`MCS_IN_PGM] && !combo_q)
                        mode_pgm_q <= mode_inc(mode_pgm_q);
                     if (rel[`MCS_IN_AUD] && !combo_q)
                        mode_aud_q <= mode_inc(mode_aud_q);
                     if (prs[`MCS_IN_INP])
                        mode_inp_q <= mode_inc(mode_inp_q);
                  end
               end
               default: st_q <= ST_RUN;
            endcase
         end

         // registered outputs
         SETUP_ACTIVE      <= (st_q != ST_RUN);
         PROGRAM_BUS_SEL   <= pgm_sel;
         AUDITION_BUS_SEL  <= aud_sel;
         INPUT_TWO_SELECT  <= inp_two;
         INPUT_ONE_SELECT  <= ~inp_two;
         PREFADE_LISTEN_ON <= pfl_q;
         CHANNEL_ON        <= chan_eff;
         CHANNEL_LIVE      <= live;
         FADER_FORCED      <= fader_frc;
         for (k = 0; k < 2; k = k + 1) begin
            GPIO_OE[k]  <= func_q[k][`MCS_FN_OUT];
            GPIO_OUT[k] <= out_act[k] ~^ func_q[k][`MCS_FN_AH];
         end
         case (st_q)
            ST_RUN: begin
               PROGRAM_BUS_LED    <= pgm_sel;
               AUDITION_BUS_LED   <= aud_sel;
               PREFADE_LISTEN_LED <= pfl_q;
               INPUT_TWO_LED      <= inp_two;
               if (on_gpio) begin
                  ON_RED_LED   <= red_in;
                  ON_GREEN_LED <= green_in;
               end else begin
                  ON_RED_LED   <= (ON_MODE != `MCS_ON_DARK) & chan_eff & ~live;
                  ON_GREEN_LED <= (ON_MODE != `MCS_ON_DARK) & live;
               end
            end
            ST_RP_FUNC, ST_RP_ACT: begin
               // same LED code for function and action lists
               PROGRAM_BUS_LED    <= fast_lit;
               ON_GREEN_LED       <= (st_q == ST_RP_FUNC) ? cur_func[0] : cur_act[0];
               ON_RED_LED         <= 1'b0;
               PREFADE_LISTEN_LED <= (st_q == ST_RP_FUNC) ? cur_func[1] : cur_act[1];
               AUDITION_BUS_LED   <= (st_q == ST_RP_FUNC) ? cur_func[2] : cur_act[2];
               INPUT_TWO_LED      <= 1'b0;
            end
            ST_BM: begin
               PROGRAM_BUS_LED    <= flash_lit(mode_pgm_q, slot_q);
               AUDITION_BUS_LED   <= flash_lit(mode_aud_q, slot_q);
               INPUT_TWO_LED      <= flash_lit(mode_inp_q, slot_q);
               PREFADE_LISTEN_LED <= 1'b0;
               ON_RED_LED         <= 1'b0;
               ON_GREEN_LED       <= 1'b0;
            end
            default: begin
               PROGRAM_BUS_LED    <= fast_lit;
               AUDITION_BUS_LED   <= 1'b0;
               PREFADE_LISTEN_LED <= 1'b0;
               INPUT_TWO_LED      <= 1'b0;
               ON_RED_LED         <= 1'b0;
               ON_GREEN_LED       <= 1'b0;
            end
         endcase
      end
   end

endmodule

// [verilog/mcs_debounce.v]
// two-stage synchroniser and debounce filter for panel and remote inputs
`timescale 1ns/1ps
`include "mcs_map.vh"

module mcs_debounce #(
   parameter        W   = `MCS_IN_W,
   parameter [31:0] CYC = `MCS_DEBOUNCE_CYC
)(
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   reg [31:0]  cnt_q;

   always @(posedge clk) begin
      if (!rst_n) begin
         s1_q  <= {W{1'b0}};
         s2_q  <= {W{1'b0}};
         s3_q  <= {W{1'b0}};
         cnt_q <= 32'h0;
         dout  <= {W{1'b0}};
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // restart the quiet period on any change
         if (s2_q != s3_q) begin
            cnt_q <= 32'h0;
         end else if (cnt_q >= CYC - 32'h1) begin
            dout <= s3_q;
         end else begin
            cnt_q <= cnt_q + 32'h1;
         end
      end
   end
endmodule

// [verilog/mcs_map.vh]
// constant map for the mixer channel setup control
`ifndef MCS_MAP_VH
`define MCS_MAP_VH

// clock rate and timing figures
`define MCS_CLK_KHZ        50000
`define MCS_ENTER_HOLD_MS  5000
`define MCS_EXIT_HOLD_MS   2000
`define MCS_CONFIRM_MS     1000
`define MCS_SHOW_DELAY_MS  500
`define MCS_FLASH_HALF_MS  250
`define MCS_MOM_PULSE_MS   200
`define MCS_DEBOUNCE_US    10
`define MCS_ENTER_CYC      (`MCS_ENTER_HOLD_MS * `MCS_CLK_KHZ)
`define MCS_EXIT_CYC       (`MCS_EXIT_HOLD_MS * `MCS_CLK_KHZ)
`define MCS_CONFIRM_CYC    (`MCS_CONFIRM_MS * `MCS_CLK_KHZ)
`define MCS_SHOW_CYC       (`MCS_SHOW_DELAY_MS * `MCS_CLK_KHZ)
`define MCS_FLASH_CYC      (`MCS_FLASH_HALF_MS * `MCS_CLK_KHZ)
`define MCS_MOM_CYC        (`MCS_MOM_PULSE_MS * `MCS_CLK_KHZ)
`define MCS_DEBOUNCE_CYC   ((`MCS_DEBOUNCE_US * `MCS_CLK_KHZ + 999) / 1000)
`define MCS_FAST_BIT       21

// debounced input vector positions
`define MCS_IN_PGM         0
`define MCS_IN_AUD         1
`define MCS_IN_PFL         2
`define MCS_IN_ON          3
`define MCS_IN_INP         4
`define MCS_IN_FADER       5
`define MCS_IN_GPIO        6
`define MCS_IN_W           8

// remote pin function bits
`define MCS_FN_MOM         0
`define MCS_FN_AH          1
`define MCS_FN_OUT         2

// remote pin action codes
`define MCS_ACT_NONE       3'h0
`define MCS_ACT_CHAN       3'h1
`define MCS_ACT_RED        3'h2
`define MCS_ACT_GREEN      3'h3
`define MCS_ACT_FADER      3'h4

// button modes
`define MCS_MODE_NORMAL    2'h1
`define MCS_MODE_FORCE_A   2'h2
`define MCS_MODE_FORCE_B   2'h3
`define MCS_ON_DARK        4'h3
`define MCS_ON_GPIO_A      4'h5
`define MCS_ON_GPIO_B      4'h6

// reset values
`define MCS_RST_FUNC       3'h0
`define MCS_RST_ACT        3'h0
`define MCS_RST_MODE       2'h1

// retained configuration word layout
`define MCS_NV_W           18
`define MCS_NV_FUNC0       0
`define MCS_NV_ACT0        3
`define MCS_NV_FUNC1       6
`define MCS_NV_ACT1        9
`define MCS_NV_PGM         12
`define MCS_NV_AUD         14
`define MCS_NV_INP         16

`endif

// [verilog/unused_placeholder_removed.v]
// timescale setting only; this file holds no module
`timescale 1ns/1ps
